// ===== include/machine_check_defs.svh
// constants of the machine check and redundancy checking block
`ifndef MACHINE_CHECK_DEFS_SVH
`define MACHINE_CHECK_DEFS_SVH

// exception vector, decimal 18
`define MC_VECTOR       8'h12

// fault cycle log field positions
`define CYC_VALID_BIT   0
`define CYC_MIO_BIT     1
`define CYC_DC_BIT      2
`define CYC_WR_BIT      3
`define CYC_LOCK_BIT    4

// model register read selects
`define SEL_ADDR_LOG    1'h0
`define SEL_CYCLE_LOG   1'h1

// reset values
`define LOG_VALID_RST   1'h0
`define MCE_RST         1'h0

// timing counts in clocks
`define STATUS_DELAY    2
`define MISMATCH_DELAY  2
`define ARM_DELAY       2

`endif

// ===== include/machine_check_pkg.sv
// types of the machine check and redundancy checking block
package machine_check_pkg;

  typedef enum logic [1:0] {
    MC_IDLE,
    MC_PENDING,
    MC_SERVICE,
    MC_SERVICE_QUEUED
  } mc_state_t;

endpackage

// ===== rtl/machine_check_and_redundancy.sv
// machine check logging, abort request and master/checker comparison
//
// Notes on behaviour
// - read parity error logs only when parity check enable was active
// - parity status is driven for every read, enable or not
// - machine check is delivered on vector 18
// - enable bit allows exception when 1, inhibits at 0, reset clears
// - abort, not restartable, no error code pushed
// - bus error, or parity error with checking enabled, latches logs always; exception only if enabled
// - latching logs sets log valid; contents undefined while clear
// - address and cycle logs are 64-bit read-only registers
// - reading the cycle log clears log valid
// - latch in same clock as read leaves valid set; reset clears it
// - cycle log holds memory/io, data/code, write/read and lock bits
// - bus error sampled at every burst ready, reads and writes
// - one pending machine check; one more remembered during service
// - bus error logs latch at last ready; next cycle may overwrite
// - checker tristates outputs and flags mismatches each clock
// - checker select low during reset picks checker, fixed at release
// - each mismatch gives one low error clock, two clocks later
// - error inactive in reset; armed three clocks after first strobe
// - compare pin value to core value; test data out excluded
`timescale 1ns/10ps
`include "machine_check_defs.svh"

module machine_check_and_redundancy
  import machine_check_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 64,
  parameter int PIN_W  = 16
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              address_strobe_n_in,
  input  wire logic              burst_ready_n_in,
  input  wire logic              last_ready_in,
  input  wire logic              bus_error_n_in,
  input  wire logic              parity_check_enable_n_in,
  input  wire logic [ADDR_W-1:0] cycle_addr_in,
  input  wire logic              cycle_mio_in,
  input  wire logic              cycle_dc_in,
  input  wire logic              cycle_wr_in,
  input  wire logic              cycle_lock_in,
  input  wire logic [DATA_W-1:0] read_data_in,
  input  wire logic [DATA_W/8-1:0] read_parity_in,
  output logic                   parity_status_n_out,
  input  wire logic              mce_write_in,
  input  wire logic              mce_data_in,
  output logic                   machine_check_enable_out,
  input  wire logic              instr_boundary_in,
  input  wire logic              service_done_in,
  output logic                   mc_take_out,
  output logic [7:0]             mc_vector_out,
  output logic                   mc_abort_out,
  output logic                   mc_push_error_code_out,
  input  wire logic              model_register_read_in,
  input  wire logic              model_register_sel_in,
  output logic [63:0]            model_register_data_out,
  output logic                   model_register_valid_out,
  input  wire logic              checker_select_n_in,
  input  wire logic [PIN_W-1:0]  core_pins_in,
  input  wire logic [PIN_W-1:0]  pins_in,
  output logic [PIN_W-1:0]       pins_out,
  output logic [PIN_W-1:0]       pins_oe_out,
  input  wire logic              internal_parity_err_in,
  output logic                   internal_error_n_out
);

  initial begin
    if (ADDR_W < 1 || ADDR_W > 64 || DATA_W < 8 || DATA_W % 8 != 0 ||
        PIN_W < 1) begin
      $error("unsupported parameter values");
    end
  end

  // even parity check over every byte lane
  function automatic logic parity_bad(input logic [DATA_W-1:0] d,
                                      input logic [DATA_W/8-1:0] p);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < DATA_W / 8; i++) begin
      bad = bad | (^{d[i*8 +: 8], p[i]});
    end
    return bad;
  endfunction

  // ==========================================================
  // reset release
  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // ==========================================================
  // bus cycle events
  logic ready;
  logic read_beat;
  logic par_err;
  logic bus_err_now;
  logic cyc_err_r;
  logic latch;

  assign ready       = !burst_ready_n_in;
  assign read_beat   = ready && !cycle_wr_in;
  assign par_err     = read_beat && parity_bad(read_data_in, read_parity_in);
  assign bus_err_now = ready && !bus_error_n_in;
  // one latch per cycle, however many causes it had
  assign latch       = ready && last_ready_in &&
                       (cyc_err_r || bus_err_now ||
                        (par_err && !parity_check_enable_n_in));

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cyc_err_r <= 1'b0;
    end else if (ready && last_ready_in) begin
      cyc_err_r <= 1'b0;
    end else if (bus_err_now ||
                 (par_err && !parity_check_enable_n_in)) begin
      cyc_err_r <= 1'b1;
    end
  end

  // ==========================================================
  // parity status pipeline
  logic [`STATUS_DELAY-1:0] status_pipe_r;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      status_pipe_r <= '0;
    end else begin
      status_pipe_r <= {status_pipe_r[`STATUS_DELAY-2:0], par_err};
    end
  end

  assign parity_status_n_out = !status_pipe_r[`STATUS_DELAY-1];

  // ==========================================================
  // fault logs
  logic [63:0] fault_address_log_r;
  logic [4:1]  cycle_info_r;
  logic        log_valid_r;
  logic        cyc_read;

  assign cyc_read = model_register_read_in &&
                    model_register_sel_in == `SEL_CYCLE_LOG;

  always_ff @(posedge clk_in) begin
    if (latch) begin
      fault_address_log_r <= 64'(cycle_addr_in);
      cycle_info_r <= {cycle_lock_in, cycle_wr_in,
                       cycle_dc_in, cycle_mio_in};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      log_valid_r <= `LOG_VALID_RST;
    end else if (latch) begin
      log_valid_r <= 1'b1;
    end else if (cyc_read) begin
      log_valid_r <= 1'b0;
    end
  end

  // ==========================================================
  // model register read port
  logic [63:0] cycle_log;

  always_comb begin
    cycle_log = 64'h0000_0000_0000_0000;
    cycle_log[`CYC_VALID_BIT] = log_valid_r;
    cycle_log[`CYC_MIO_BIT]   = cycle_info_r[1];
    cycle_log[`CYC_DC_BIT]    = cycle_info_r[2];
    cycle_log[`CYC_WR_BIT]    = cycle_info_r[3];
    cycle_log[`CYC_LOCK_BIT]  = cycle_info_r[4];
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      model_register_data_out  <= 64'h0000_0000_0000_0000;
      model_register_valid_out <= 1'b0;
    end else begin
      model_register_valid_out <= model_register_read_in;
      if (model_register_read_in) begin
        model_register_data_out <= cyc_read ? cycle_log
                                            : fault_address_log_r;
      end
    end
  end

  // ==========================================================
  // machine check enable and exception sequencing
  logic      mce_r;
  logic      raise;
  mc_state_t mc_state_r;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mce_r <= `MCE_RST;
    end else if (mce_write_in) begin
      mce_r <= mce_data_in;
    end
  end

  assign machine_check_enable_out = mce_r;
  assign raise = latch && mce_r;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mc_state_r <= MC_IDLE;
    end else begin
      unique case (mc_state_r)
        MC_IDLE: begin
          if (raise) begin
            mc_state_r <= MC_PENDING;
          end
        end
        MC_PENDING: begin
          if (instr_boundary_in) begin
            mc_state_r <= MC_SERVICE;
          end
        end
        MC_SERVICE: begin
          if (service_done_in) begin
            mc_state_r <= raise ? MC_PENDING : MC_IDLE;
          end else if (raise) begin
            mc_state_r <= MC_SERVICE_QUEUED;
          end
        end
        MC_SERVICE_QUEUED: begin
          if (service_done_in) begin
            mc_state_r <= MC_PENDING;
          end
        end
      endcase
    end
  end

  assign mc_take_out            = mc_state_r == MC_PENDING &&
                                  instr_boundary_in;
  assign mc_vector_out          = `MC_VECTOR;
  assign mc_abort_out           = mc_take_out;
  assign mc_push_error_code_out = 1'b0;

  // ==========================================================
  // master/checker configuration and comparison
  logic                       checker_mode_r;
  logic                       armed_r;
  logic [`ARM_DELAY-1:0]      ads_hist_r;
  logic                       mismatch;
  logic [`MISMATCH_DELAY-1:0] err_pipe_r;

  // follows the strap while in reset, frozen from the release on
  always_ff @(posedge clk_in) begin
    if (!rst_n) begin
      checker_mode_r <= !checker_select_n_in;
    end
  end

  assign pins_out    = core_pins_in;
  assign pins_oe_out = checker_mode_r ? '0 : '1;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ads_hist_r <= '0;
      armed_r    <= 1'b0;
    end else begin
      ads_hist_r <= {ads_hist_r[`ARM_DELAY-2:0], !address_strobe_n_in};
      if (ads_hist_r[`ARM_DELAY-1]) begin
        armed_r <= 1'b1;
      end
    end
  end

  // compare against the core value, never a scan value
  assign mismatch = checker_mode_r && armed_r &&
                    (pins_in != core_pins_in);

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      err_pipe_r <= '0;
    end else begin
      err_pipe_r <= {err_pipe_r[`MISMATCH_DELAY-2:0], mismatch};
    end
  end

  // internal parity errors bypass the arming delay
  assign internal_error_n_out = !rst_n ? 1'b1 :
                                !(err_pipe_r[`MISMATCH_DELAY-1] ||
                                  internal_parity_err_in);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence s_bad_read;
    par_err;
  endsequence

  sequence s_status_low;
    ##2 !parity_status_n_out;
  endsequence

  property p_status_two;
    s_bad_read |-> s_status_low;
  endproperty
  a_status_two: assert property (p_status_two)
    else $error("parity status not low two clocks after bad read");

  property p_bus_err_log;
    (bus_err_now && last_ready_in) |=>
      (log_valid_r && fault_address_log_r == 64'($past(cycle_addr_in)));
  endproperty
  a_bus_err_log: assert property (p_bus_err_log)
    else $error("bus error at last ready did not latch the logs");

  property p_quiet_read;
    (par_err && parity_check_enable_n_in && !cyc_err_r && !bus_err_now &&
     last_ready_in && !log_valid_r && !cyc_read) |=> !log_valid_r;
  endproperty
  a_quiet_read: assert property (p_quiet_read)
    else $error("parity error logged with checking disabled");

  property p_read_clear;
    (cyc_read && !latch) |=> !log_valid_r;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("cycle log read left valid set");

  property p_set_wins;
    (cyc_read && latch) |=> log_valid_r;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("latch lost against a cycle log read");

  property p_mce_off;
    (mc_state_r == MC_IDLE && !mce_r) |=> mc_state_r == MC_IDLE;
  endproperty
  a_mce_off: assert property (p_mce_off)
    else $error("machine check raised while disabled");

  property p_take;
    mc_take_out |-> (mc_vector_out == 8'h12 && !mc_push_error_code_out)
                    ##1 mc_state_r == MC_SERVICE;
  endproperty
  a_take: assert property (p_take)
    else $error("take did not enter service on vector 18");

  property p_queue;
    (mc_state_r == MC_SERVICE && raise && !service_done_in) |=>
      (mc_state_r == MC_SERVICE_QUEUED);
  endproperty
  a_queue: assert property (p_queue)
    else $error("second event during service not remembered");

  property p_mismatch;
    mismatch |-> ##2 !internal_error_n_out;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("mismatch not reported two clocks later");

  property p_mode_fixed;
    $stable(checker_mode_r);
  endproperty
  a_mode_fixed: assert property (p_mode_fixed)
    else $error("checker mode changed outside reset");

  property p_tristate;
    checker_mode_r |-> pins_oe_out == '0;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("checker drives its outputs");

endmodule // machine_check_and_redundancy

// ===== tb/bus_ctrl_model.sv
// system bus controller model running one two-beat bus cycle per request
`timescale 1ns/10ps

module bus_ctrl_model (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [3:0]  lvl_in,
  input  wire logic        bad_in,
  input  wire logic        err_in,
  input  wire logic        pen_in,
  output logic             busy_out,
  output logic             ads_n_out,
  output logic             rdy_n_out,
  output logic             last_out,
  output logic             berr_n_out,
  output logic             pen_n_out,
  output logic [31:0]      addr_out,
  output logic [3:0]       lvl_out,
  output logic [63:0]      data_out,
  output logic [7:0]       par_out
);
  logic [1:0] ph_r;

  initial begin
    ph_r = 2'h0;
    {ads_n_out, rdy_n_out, berr_n_out, pen_n_out, last_out} = 5'h1E;
    addr_out = 32'h0;
    lvl_out = 4'h0;
    data_out = 64'h0;
    par_out = 8'h0;
  end

  assign busy_out = (ph_r != 2'h0);

  // ==========================================================
  // cycle sequencer
  always @(posedge clk_in) begin
    if (ph_r == 2'h1 || ph_r == 2'h2) begin
      data_out <= {8{8'hA5}};
      par_out  <= bad_in ? 8'h01 : 8'h00;
    end else begin
      // no beat: data lines never hold the last value
      data_out <= ~data_out;
      par_out  <= ~par_out;
    end
    case (ph_r)
      2'h0: if (go_in) begin
        ph_r      <= 2'h1;
        ads_n_out <= 1'b0;
        addr_out  <= addr_in;
        lvl_out   <= lvl_in;
      end
      2'h1: begin
        ph_r       <= 2'h2;
        ads_n_out  <= 1'b1;
        rdy_n_out  <= 1'b0;
        berr_n_out <= ~err_in;
        pen_n_out  <= ~pen_in;
      end
      2'h2: begin
        ph_r       <= 2'h3;
        last_out   <= 1'b1; // ready kept to the end
        berr_n_out <= 1'b1; // error dropped before next ready
      end
      default: begin
        ph_r      <= 2'h0;
        rdy_n_out <= 1'b1;
        last_out  <= 1'b0;
        pen_n_out <= 1'b1;
      end
    endcase
  end
endmodule // bus_ctrl_model

// ===== tb/machine_check_and_redundancy_bench.sv
// self-checking bench of the machine check and redundancy block
`timescale 1ns/10ps

module machine_check_and_redundancy_bench;
  import machine_check_pkg::*;
  logic        clk, rst_n, go, bad, err, pen, busy, ads_n, rdy_n, last;
  logic        berr_n, pen_n, mce_wr, mce_d, bnd, done, rd, sel, sel_n, ipe;
  logic        pst_n, mce, take, abrt, push, vld, internal_error_out_n;
  logic [31:0] addr, c_addr;
  logic [3:0]  lvl, c_lvl;
  logic [63:0] data, rdata;
  logic [7:0]  par, vec;
  logic [15:0] core, pins, poe, pout;
  int          errors, check_count, st_cnt, tk_cnt, ie_cnt, cyc;

  bus_ctrl_model ctl (.clk_in(clk), .go_in(go), .addr_in(addr),
    .lvl_in(lvl), .bad_in(bad), .err_in(err), .pen_in(pen),
    .busy_out(busy), .ads_n_out(ads_n), .rdy_n_out(rdy_n),
    .last_out(last), .berr_n_out(berr_n), .pen_n_out(pen_n),
    .addr_out(c_addr), .lvl_out(c_lvl), .data_out(data), .par_out(par));

  machine_check_and_redundancy uut (.clk_in(clk), .rst_n_in(rst_n),
    .address_strobe_n_in(ads_n), .burst_ready_n_in(rdy_n),
    .last_ready_in(last), .bus_error_n_in(berr_n),
    .parity_check_enable_n_in(pen_n), .cycle_addr_in(c_addr),
    .cycle_mio_in(c_lvl[0]), .cycle_dc_in(c_lvl[1]),
    .cycle_wr_in(c_lvl[2]), .cycle_lock_in(c_lvl[3]),
    .read_data_in(data), .read_parity_in(par),
    .parity_status_n_out(pst_n), .mce_write_in(mce_wr),
    .mce_data_in(mce_d), .machine_check_enable_out(mce),
    .instr_boundary_in(bnd), .service_done_in(done),
    .mc_take_out(take), .mc_vector_out(vec), .mc_abort_out(abrt),
    .mc_push_error_code_out(push), .model_register_read_in(rd),
    .model_register_sel_in(sel), .model_register_data_out(rdata),
    .model_register_valid_out(vld), .checker_select_n_in(sel_n),
    .core_pins_in(core), .pins_in(pins), .pins_out(pout),
    .pins_oe_out(poe), .internal_parity_err_in(ipe),
    .internal_error_n_out(internal_error_out_n));

  always #4 clk = ~clk;

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic run(input logic [31:0] a, input logic [3:0] l,
                     input logic b, input logic e, input logic p);
    @(posedge clk);
    go <= 1'b1;
    addr <= a;
    lvl <= l;
    bad <= b;
    err <= e;
    pen <= p;
    @(posedge clk);
    go <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
  endtask

  task automatic rd_reg(input logic s, input logic [63:0] exp,
                        input logic [63:0] msk);
    @(posedge clk);
    rd <= 1'b1;
    sel <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({63'h0, vld}, 64'h1);
    chk(rdata & msk, exp);
  endtask

  task automatic pulse(input int which, input logic v);
    @(posedge clk);
    if (which == 0) begin
      mce_wr <= 1'b1;
      mce_d <= v;
    end else if (which == 1) begin
      done <= 1'b1;
    end else begin
      ipe <= 1'b1;
    end
    @(posedge clk);
    {mce_wr, done, ipe} <= 3'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic reset_dut(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    sel_n <= s;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic mism(input int n);
    @(posedge clk);
    pins <= ~core;
    repeat (n) @(posedge clk);
    pins <= core; // checker sees the master's pin states
    repeat (4) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // monitors and timeout
  always @(posedge clk) begin
    cyc++;
    if (pst_n === 1'b0) st_cnt++;
    if (internal_error_out_n === 1'b0) ie_cnt++;
    if (take === 1'b1) begin
      tk_cnt++;
      chk({55'h0, abrt, vec}, {55'h0, 1'b1, 8'h12});
      chk({63'h0, push}, 64'h0);
    end
    if (cyc >= 3000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    {clk, rst_n, go, bad, err, pen, mce_wr, mce_d} = 8'h0;
    {done, rd, sel, ipe} = 4'h0;
    {bnd, sel_n} = 2'h3;
    addr = 32'h0;
    lvl = 4'h0;
    core = 16'h1234;
    pins = 16'h1234;
    {errors, check_count, st_cnt, tk_cnt, ie_cnt, cyc} = '0;
    reset_dut(1'b1);
    chk({63'h0, mce}, 64'h0);
    chk({48'h0, poe}, 64'hFFFF);
    chk({48'h0, pout}, 64'h1234);
    rd_reg(1'b1, 64'h0, 64'h1);
    run(32'h0001_2340, 4'b0001, 1'b1, 1'b0, 1'b1);
    chk(64'(st_cnt), 64'h2);
    chk(64'(tk_cnt), 64'h0);
    rd_reg(1'b0, 64'h12340, '1);
    rd_reg(1'b1, 64'h3, '1);
    rd_reg(1'b1, 64'h0, 64'h1);
    run(32'h0000_0100, 4'b0001, 1'b1, 1'b0, 1'b0);
    chk(64'(st_cnt), 64'h4);
    rd_reg(1'b1, 64'h0, 64'h1);
    pulse(0, 1'b1);
    chk({63'h0, mce}, 64'h1);
    run(32'hFFFF_FFF0, 4'b1110, 1'b0, 1'b1, 1'b0);
    chk(64'(tk_cnt), 64'h1);
    rd_reg(1'b0, 64'hFFFF_FFF0, '1);
    rd_reg(1'b1, 64'h1D, '1);
    run(32'h0000_0040, 4'b0000, 1'b0, 1'b1, 1'b0);
    chk(64'(tk_cnt), 64'h1);
    pulse(1, 1'b0);
    chk(64'(tk_cnt), 64'h2);
    pulse(1, 1'b0);
    run(32'h0000_0080, 4'b0001, 1'b1, 1'b1, 1'b1);
    chk(64'(tk_cnt), 64'h3);
    pulse(1, 1'b0);
    chk(64'(tk_cnt), 64'h3);
    rd_reg(1'b1, 64'h3, '1);
    pulse(0, 1'b0);
    run(32'h0000_0A00, 4'b0001, 1'b0, 1'b1, 1'b0);
    run(32'h0000_0B00, 4'b0101, 1'b0, 1'b1, 1'b0);
    chk(64'(tk_cnt), 64'h3);
    rd_reg(1'b0, 64'h0B00, '1);
    rd_reg(1'b1, 64'hB, '1);
    mism(3);
    chk(64'(ie_cnt), 64'h0);
    pulse(2, 1'b0);
    chk(64'(ie_cnt), 64'h1);
    reset_dut(1'b0);
    chk({48'h0, poe}, 64'h0);
    @(posedge clk);
    sel_n <= 1'b1;
    ie_cnt = 0;
    mism(3);
    chk(64'(ie_cnt), 64'h0);
    run(32'h0000_0200, 4'b0001, 1'b0, 1'b0, 1'b0);
    mism(3);
    chk(64'(ie_cnt), 64'h3);
    chk({48'h0, poe}, 64'h0);
    wrap_up();
  end
endmodule // machine_check_and_redundancy_bench
